/* design/opdec_pkg.sv */
package opdec_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FLAGS = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_SNAP = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0c;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam logic CTRL_ENABLE_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Status flag word layout
  // ----------------------------------------------------------------
  localparam int FLAG_CF = 0;
  localparam int FLAG_PF = 2;
  localparam int FLAG_AF = 4;
  localparam int FLAG_ZF = 6;
  localparam int FLAG_SF = 7;
  localparam int FLAG_TF = 8;
  localparam int FLAG_IF = 9;
  localparam int FLAG_DF = 10;
  localparam int FLAG_OF = 11;
  localparam logic [15:0] FLAG_ONE = 16'h0001;
  localparam logic [15:0] FLAG_DEFINED_MASK = (FLAG_ONE << FLAG_CF) | (FLAG_ONE << FLAG_PF)
    | (FLAG_ONE << FLAG_AF) | (FLAG_ONE << FLAG_ZF) | (FLAG_ONE << FLAG_SF) | (FLAG_ONE << FLAG_TF)
    | (FLAG_ONE << FLAG_IF) | (FLAG_ONE << FLAG_DF) | (FLAG_ONE << FLAG_OF);
  localparam logic [15:0] FLAGS_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Opcode field positions and patterns
  // ----------------------------------------------------------------
  localparam int OP_W_BIT = 0;
  localparam int OP_D_BIT = 1;
  localparam int OP_S_BIT = 1;
  localparam int OP_V_BIT = 1;
  localparam int OP_Z_BIT = 0;
  localparam int SEG_FIELD_LSB = 3;
  localparam logic [7:0] SEG_PREFIX_MASK = 8'he7;
  localparam logic [7:0] SEG_PREFIX_VAL = 8'h26;
  localparam logic [7:0] REP_MASK = 8'hfe;
  localparam logic [7:0] REP_VAL = 8'hf2;
  localparam logic [7:0] STR_MASK = 8'hfe;
  localparam logic [7:0] STR_MOVE = 8'ha4;
  localparam logic [7:0] STR_CMP = 8'ha6;
  localparam logic [7:0] STR_STORE = 8'haa;
  localparam logic [7:0] STR_LOAD = 8'hac;
  localparam logic [7:0] STR_SCAN = 8'hae;
  localparam logic [7:0] GRP_MASK = 8'hfc;
  localparam logic [7:0] SHIFT_VAL = 8'hd0;
  localparam logic [7:0] IMM_GRP_VAL = 8'h80;
  localparam logic [1:0] IMM_FORM_WORD = 2'b01;
  localparam logic [1:0] IMM_FORM_SEXT = 2'b11;
  localparam logic [2:0] RM_DIRECT = 3'b110;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SEG_ES = 2'b00, SEG_CS = 2'b01, SEG_SS = 2'b10, SEG_DS = 2'b11} seg_t;
  typedef enum logic [1:0] {DISP_NONE = 2'b00, DISP_BYTE_SEXT = 2'b01, DISP_WORD = 2'b10,
                            DISP_REG = 2'b11} disp_kind_t;
  typedef enum logic [3:0] {REG_AX, REG_CX, REG_DX, REG_BX, REG_SP, REG_BP, REG_SI, REG_DI,
                            REG_AL, REG_CL, REG_DL, REG_BL, REG_AH, REG_CH, REG_DH, REG_BH} reg_id_t;
  typedef enum {ST_OPCODE, ST_MODRM} fsm_t;

  typedef struct packed {
    logic has_modrm;
    logic reg_is_dest;
    logic word_op;
    logic imm_word;
    logic imm_sext;
    logic count_one;
    logic count_from_cl;
    logic is_string;
    logic is_cmp_string;
  } op_ctrl_t;

  typedef struct packed {
    disp_kind_t disp_kind;
    logic direct_addr;
    reg_id_t reg_name;
    reg_id_t rm_name;
    seg_t mem_seg;
  } modrm_ctrl_t;

  typedef struct packed {
    op_ctrl_t op;
    modrm_ctrl_t mrm;
    seg_t src_seg;
    seg_t dst_seg;
    seg_t code_seg;
    logic rep_active;
    logic rep_z;
    logic rep_stop;
  } dec_out_t;

  typedef struct packed {
    disp_kind_t disp_kind;
    logic reg_is_dest;
    logic word_op;
    seg_t mem_seg;
    logic [7:0] modrm;
    logic [7:0] opcode;
  } snap_t;

  typedef struct packed {
    logic [31:0] flags_word;
    logic [31:0] ctrl_word;
    logic [31:0] snap_word;
    logic [31:0] count_word;
  } reg_view_t;

  typedef struct packed {
    logic flags_lo;
    logic flags_hi;
    logic ctrl;
    logic [31:0] data;
  } reg_wr_t;

endpackage

/* design/field_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
module field_decoder
  import opdec_pkg::*;
(
  input wire logic [7:0] opcode, // Opcode byte
  input wire logic [7:0] modrm, // Second byte, zero when absent
  input wire logic ovr_valid, // Segment override pending
  input wire seg_t ovr_seg, // Override segment
  output op_ctrl_t op, // Opcode field controls
  output modrm_ctrl_t mrm, // Second byte controls
  output seg_t src_seg, // String source segment
  output seg_t dst_seg // String destination segment
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic reg_id_t reg_name(input logic [2:0] field, input logic word);
    reg_name = reg_id_t'({~word, field}); // RQ13
  endfunction

  function automatic logic needs_modrm(input logic [7:0] b);
    needs_modrm = ((b[7:6] == 2'b00) && !b[2]) || ((b & GRP_MASK) == IMM_GRP_VAL)
      || (b[7:2] == 6'b100001) || (b[7:2] == 6'b100010) || (b[7:2] == 6'b100011)
      || (b[7:2] == 6'b110001) || ((b & GRP_MASK) == SHIFT_VAL)
      || (b[7:1] == 7'b1111011) || (b[7:1] == 7'b1111111);
  endfunction

  function automatic logic is_str(input logic [7:0] b);
    logic [7:0] m;
    m = b & STR_MASK;
    is_str = (m == STR_MOVE) || (m == STR_CMP) || (m == STR_STORE) || (m == STR_LOAD) || (m == STR_SCAN);
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic bp_based;
  logic [1:0] imm_form;
  logic is_shift;

  always_comb begin
    imm_form = {opcode[OP_S_BIT], opcode[OP_W_BIT]};
    is_shift = (opcode & GRP_MASK) == SHIFT_VAL;
    op.has_modrm = needs_modrm(opcode);
    op.reg_is_dest = opcode[OP_D_BIT]; // RQ4
    op.word_op = opcode[OP_W_BIT]; // RQ5
    op.imm_word = ((opcode & GRP_MASK) == IMM_GRP_VAL) && (imm_form == IMM_FORM_WORD); // RQ6
    op.imm_sext = ((opcode & GRP_MASK) == IMM_GRP_VAL) && (imm_form == IMM_FORM_SEXT); // RQ6
    op.count_one = is_shift && !opcode[OP_V_BIT]; // RQ7
    op.count_from_cl = is_shift && opcode[OP_V_BIT]; // RQ7
    op.is_string = is_str(opcode);
    op.is_cmp_string = ((opcode & STR_MASK) == STR_CMP) || ((opcode & STR_MASK) == STR_SCAN);
    // Mode field picks displacement size or register operand
    mrm.disp_kind = disp_kind_t'(modrm[7:6]); // RQ15
    mrm.direct_addr = (modrm[7:6] == DISP_NONE) && (modrm[2:0] == RM_DIRECT);
    if (mrm.direct_addr) begin
      mrm.disp_kind = DISP_WORD;
    end
    mrm.reg_name = reg_name(modrm[5:3], opcode[OP_W_BIT]); // RQ13
    mrm.rm_name = reg_name(modrm[2:0], opcode[OP_W_BIT]); // RQ13
    // Operands built on the base pointer live in the stack segment
    bp_based = (modrm[2:0] == 3'b010) || (modrm[2:0] == 3'b011)
      || ((modrm[2:0] == RM_DIRECT) && !mrm.direct_addr);
    if (ovr_valid) begin
      mrm.mem_seg = ovr_seg; // RQ9
    end else if (bp_based) begin
      mrm.mem_seg = SEG_SS; // RQ10
    end else begin
      mrm.mem_seg = SEG_DS; // RQ11
    end
    src_seg = ovr_valid ? ovr_seg : SEG_DS; // RQ11
    dst_seg = SEG_ES; // RQ12
  end

endmodule
`default_nettype wire

/* design/wb_reg_slave.sv */
`timescale 1ns/1ns
`default_nettype none
module wb_reg_slave
  import opdec_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic reset_n, // Async reset, active low
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Strobe
  input wire logic we_i, // Write enable
  input wire logic [7:0] adr_i, // Byte address
  input wire logic [31:0] dat_i, // Write data
  input wire logic [3:0] sel_i, // Byte lanes
  output logic [31:0] dat_o, // Read data
  output logic ack_o, // Acknowledge
  input wire reg_view_t view, // Register read values
  output reg_wr_t wr // Write strobes
);

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } slave_state_t;

  slave_state_t q, d;
  logic req;

  // ----------------------------------------------------------------
  // Decode, one answer per request
  // ----------------------------------------------------------------
  always_comb begin
    req = cyc_i && stb_i && !q.ack;
    d.ack = req;
    d.dat = 32'h0000_0000;
    wr.flags_lo = 1'b0;
    wr.flags_hi = 1'b0;
    wr.ctrl = 1'b0;
    wr.data = dat_i;
    if (adr_i == ADDR_FLAGS) begin
      d.dat = view.flags_word;
      wr.flags_lo = req && we_i && sel_i[0];
      wr.flags_hi = req && we_i && sel_i[1];
    end else if (adr_i == ADDR_CTRL) begin
      d.dat = view.ctrl_word;
      wr.ctrl = req && we_i && sel_i[0];
    end else if (adr_i == ADDR_SNAP) begin
      d.dat = view.snap_word;
    end else if (adr_i == ADDR_COUNT) begin
      d.dat = view.count_word;
    end
    if (!req || we_i) begin
      d.dat = q.dat;
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ack_o = q.ack;
  assign dat_o = q.dat;

endmodule
`default_nettype wire

/* design/x86_opcode_field_decoder.sv */
// How it works
// RQ1: Flag word bit 9 interrupt enable, 10 direction, 11 overflow; 15..12 undefined.
// RQ2: Flag word bit 8 single-step trap, 7 sign, 6 zero.
// RQ3: Flag word bit 4 BCD aux carry, 2 parity, 0 carry; 5, 3, 1 undefined.
// RQ4: Direction bit 1 makes register the destination, 0 the source.
// RQ5: Width bit 1 selects word operation, 0 selects byte operation.
// RQ6: Immediate form 01 takes a full word; 11 sign-extends one byte.
// RQ7: Shift count source 0 means count of one, 1 means count from CL.
// RQ8: Repeat prefix low bit is compared with zero flag to end compare or scan.
// RQ9: Prefix 001ss110 overrides the memory segment of the next instruction.
// RQ10: BP-based addresses default to stack segment; code fetch always uses code segment.
// RQ11: Non-string SI/DI and string source default to data segment, overridable.
// RQ12: String destination always uses the extra segment; override ignored.
// RQ13: Register field maps 000..111 onto word or byte register names.
// RQ14: Segment field decodes 00 ES, 01 CS, 10 SS, 11 DS.
// RQ15: Mode field: 00 no displacement, 01 byte sign-extended, 10 word, 11 register.
// RQ16: Decoded controls appear in the same cycle the byte is accepted.
//
// The register offsets and the Wishbone register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module x86_opcode_field_decoder
  import opdec_pkg::*;
(
  input wire logic core_clk, // Core clock, 20 MHz
  input wire logic reset_n, // Async reset, active low
  input wire logic cyc_i, // Wishbone cycle
  input wire logic stb_i, // Wishbone strobe
  input wire logic we_i, // Wishbone write enable
  input wire logic [7:0] adr_i, // Wishbone byte address
  input wire logic [31:0] dat_i, // Wishbone write data
  input wire logic [3:0] sel_i, // Wishbone byte lanes
  output logic [31:0] dat_o, // Wishbone read data
  output logic ack_o, // Wishbone acknowledge
  input wire logic fetch_valid, // Instruction byte offered
  input wire logic [7:0] fetch_byte, // Instruction byte
  output logic fetch_ready, // Byte will be taken
  output dec_out_t dec, // Decoded controls
  output logic op_valid, // Opcode byte decoded this cycle
  output logic mrm_valid, // Second byte decoded this cycle
  input wire logic flag_load, // Datapath writes the flag word
  input wire logic [15:0] flag_value, // New flag word from datapath
  output logic [15:0] flags_out // Current flag word
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    fsm_t st;
    logic [7:0] opcode;
    logic ovr_valid;
    seg_t ovr_seg;
    logic rep_valid;
    logic rep_z;
    logic [15:0] flags;
    logic enable;
    snap_t snap;
    logic [15:0] count;
  } core_state_t;

  core_state_t q, d;
  op_ctrl_t op;
  modrm_ctrl_t mrm;
  seg_t src_seg;
  seg_t dst_seg;
  logic [7:0] cur_opcode;
  logic [7:0] cur_modrm;
  logic accept;
  logic is_seg_prefix;
  logic is_rep;
  reg_view_t view;
  reg_wr_t wr;

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  wb_reg_slave u_bus (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .dat_i(dat_i),
    .sel_i(sel_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .view(view),
    .wr(wr)
  );

  // Read values, unused bits read as zero
  always_comb begin
    view = '0;
    view.flags_word[15:0] = q.flags;
    view.ctrl_word[CTRL_ENABLE_BIT] = q.enable;
    view.snap_word[$bits(snap_t)-1:0] = q.snap;
    view.count_word[15:0] = q.count;
  end

  // ----------------------------------------------------------------
  // Field decode of the byte being accepted
  // ----------------------------------------------------------------
  assign cur_opcode = (q.st == ST_MODRM) ? q.opcode : fetch_byte;
  assign cur_modrm = (q.st == ST_MODRM) ? fetch_byte : 8'h00;

  field_decoder u_fields (
    .opcode(cur_opcode),
    .modrm(cur_modrm),
    .ovr_valid(q.ovr_valid),
    .ovr_seg(q.ovr_seg),
    .op(op),
    .mrm(mrm),
    .src_seg(src_seg),
    .dst_seg(dst_seg)
  );

  // Prefix recognition
  assign is_seg_prefix = (fetch_byte & SEG_PREFIX_MASK) == SEG_PREFIX_VAL; // RQ9
  assign is_rep = (fetch_byte & REP_MASK) == REP_VAL;

  // Handshake toward fetch
  assign fetch_ready = q.enable;
  assign accept = fetch_valid && q.enable;

  // ----------------------------------------------------------------
  // Decoded output bundle, combinational from the accepted byte
  // ----------------------------------------------------------------
  always_comb begin
    dec.op = op; // RQ16
    dec.mrm = mrm; // RQ16
    dec.src_seg = src_seg;
    dec.dst_seg = dst_seg; // RQ12
    dec.code_seg = SEG_CS; // RQ10
    dec.rep_active = q.rep_valid;
    dec.rep_z = q.rep_z; // RQ8
    // Compare and scan end when the zero flag differs from the prefix bit
    dec.rep_stop = q.rep_valid && op.is_cmp_string && (q.flags[FLAG_ZF] != q.rep_z); // RQ8
  end

  assign flags_out = q.flags;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    op_valid = 1'b0;
    mrm_valid = 1'b0;
    if (accept) begin
      d.count = q.count + COUNT_STEP;
    end
    case (q.st)
      ST_OPCODE: begin
        if (accept) begin
          if (is_seg_prefix) begin
            // Remember the segment for the next instruction
            d.ovr_valid = 1'b1; // RQ9
            d.ovr_seg = seg_t'(fetch_byte[SEG_FIELD_LSB +: 2]); // RQ14
          end else if (is_rep) begin
            d.rep_valid = 1'b1;
            d.rep_z = fetch_byte[OP_Z_BIT]; // RQ8
          end else begin
            op_valid = 1'b1; // RQ16
            d.opcode = fetch_byte;
            d.snap.opcode = fetch_byte;
            d.snap.modrm = 8'h00;
            d.snap.word_op = op.word_op;
            d.snap.reg_is_dest = op.reg_is_dest;
            d.snap.disp_kind = DISP_NONE;
            d.snap.mem_seg = op.is_string ? src_seg : mrm.mem_seg;
            if (op.has_modrm) begin
              d.st = ST_MODRM;
            end else begin
              // Prefixes apply to this instruction only
              d.ovr_valid = 1'b0;
              d.rep_valid = 1'b0;
            end
          end
        end
      end
      ST_MODRM: begin
        if (accept) begin
          mrm_valid = 1'b1; // RQ16
          d.snap.modrm = fetch_byte;
          d.snap.disp_kind = mrm.disp_kind; // RQ15
          d.snap.mem_seg = mrm.mem_seg; // RQ10
          d.st = ST_OPCODE;
          d.ovr_valid = 1'b0;
          d.rep_valid = 1'b0;
        end
      end
      default: begin
        d.st = ST_OPCODE;
      end
    endcase
    // Software control: enable and prefix flush
    if (wr.ctrl) begin
      d.enable = wr.data[CTRL_ENABLE_BIT];
      if (wr.data[CTRL_FLUSH_BIT]) begin
        d.st = ST_OPCODE;
        d.ovr_valid = 1'b0;
        d.rep_valid = 1'b0;
      end
    end
    // Flag word: software by byte lane, undefined bits held at zero
    if (wr.flags_lo) begin
      d.flags[7:0] = wr.data[7:0] & FLAG_DEFINED_MASK[7:0]; // RQ2
    end
    if (wr.flags_hi) begin
      d.flags[15:8] = wr.data[15:8] & FLAG_DEFINED_MASK[15:8]; // RQ1
    end
    // Datapath update wins over a software write in the same cycle
    if (flag_load) begin
      d.flags = flag_value & FLAG_DEFINED_MASK; // RQ3
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q.st <= ST_OPCODE;
      q.opcode <= 8'h00;
      q.ovr_valid <= 1'b0;
      q.ovr_seg <= SEG_DS;
      q.rep_valid <= 1'b0;
      q.rep_z <= 1'b0;
      q.flags <= FLAGS_RESET;
      q.enable <= CTRL_ENABLE_RESET;
      q.snap <= '0;
      q.count <= 16'h0000;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

/* testbench/fetch_src.sv */
`timescale 1ns/1ns
`default_nettype none
module fetch_src (
  input wire logic core_clk, // Clock
  input wire logic fetch_ready, // Decoder will take the byte
  output logic fetch_valid, // Byte offered
  output logic [7:0] fetch_byte // Offered byte
);
  // ------------------------------------------------------------
  // Fetch side model
  // ------------------------------------------------------------
  // Idle line holds a pattern, never a stale byte
  initial begin
    fetch_valid = 1'b0;
    fetch_byte = 8'h5a;
  end
  // Offer a byte after some idle cycles, then let decode settle
  task automatic offer(logic [7:0] b, int gap);
    repeat (gap) @(posedge core_clk);
    @(posedge core_clk);
    fetch_valid <= 1'b1;
    fetch_byte <= b;
    #1;
  endtask
  // Hold until taken, then release with the inverse on the line
  task automatic take();
    do begin
      @(posedge core_clk);
    end while (fetch_ready !== 1'b1);
    fetch_valid <= 1'b0;
    fetch_byte <= ~fetch_byte;
  endtask
endmodule
`default_nettype wire

/* testbench/decoder_checker_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module decoder_checker
  import opdec_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic cyc_i, // Bus cycle
  input wire logic stb_i, // Bus strobe
  input wire logic ack_o, // Bus acknowledge
  input wire logic fetch_valid, // Byte offered
  input wire logic [7:0] fetch_byte, // Offered byte
  input wire logic fetch_ready, // Byte taken
  input wire dec_out_t dec, // Decoded controls
  input wire logic op_valid, // Opcode decoded
  input wire logic mrm_valid, // Second byte decoded
  input wire logic flag_load, // Flag load strobe
  input wire logic [15:0] flag_value, // Flag load value
  input wire logic [15:0] flags_out // Flag word
);
  // ------------------------------------------------------------
  // Bus and fetch timing
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i && !ack_o))
    else $error("acknowledge without request");
  take_only_a: assert property (op_valid || mrm_valid |-> fetch_valid && fetch_ready && !(op_valid && mrm_valid))
    else $error("decode strobe without accepted byte");
  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  dir_width_a: assert property (op_valid && fetch_byte[7:2] == 6'b100010 |->
    dec.op.reg_is_dest == fetch_byte[1] && dec.op.word_op == fetch_byte[0])
    else $error("direction or width bit misdecoded");
  imm_form_a: assert property (op_valid && fetch_byte[7:2] == 6'b100000 |->
    dec.op.imm_sext == (fetch_byte[1:0] == 2'b11) && dec.op.imm_word == (fetch_byte[1:0] == 2'b01))
    else $error("immediate form misdecoded");
  shift_src_a: assert property (op_valid && fetch_byte[7:2] == 6'b110100 |->
    dec.op.count_from_cl == fetch_byte[1] && dec.op.count_one != fetch_byte[1])
    else $error("shift count source misdecoded");
  mode_disp_a: assert property (mrm_valid |-> dec.mrm.disp_kind ==
    ((fetch_byte[7:6] == 2'b00 && fetch_byte[2:0] == 3'b110) ? DISP_WORD : disp_kind_t'(fetch_byte[7:6])))
    else $error("mode field misdecoded");
  fixed_seg_a: assert property (op_valid |-> dec.dst_seg == SEG_ES && dec.code_seg == SEG_CS)
    else $error("fixed segment overridden");
  rep_end_a: assert property (op_valid && dec.rep_active && fetch_byte[7:1] inside {7'b1010011, 7'b1010111} |->
    dec.rep_stop == (flags_out[FLAG_ZF] != dec.rep_z))
    else $error("repeat termination wrong");
  flag_load_a: assert property (flag_load |=> flags_out == ($past(flag_value) & 16'h0fd5))
    else $error("flag word load wrong");
endmodule
bind x86_opcode_field_decoder decoder_checker i_decoder_checker (.core_clk, .reset_n, .cyc_i, .stb_i, .ack_o,
  .fetch_valid, .fetch_byte, .fetch_ready, .dec, .op_valid, .mrm_valid, .flag_load, .flag_value, .flags_out);
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench import opdec_pkg::*; ;
  logic core_clk = 1'b0, reset_n = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, flag_load = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic [3:0] sel_i = 4'h0;
  logic [15:0] flag_value = 16'h0, flags_out;
  logic ack_o, fetch_valid, fetch_ready, op_valid, mrm_valid;
  logic [7:0] fetch_byte;
  dec_out_t dec;
  int err_count = 0;
  int check_count = 0;
  x86_opcode_field_decoder i_x86_opcode_field_decoder (.core_clk, .reset_n, .cyc_i, .stb_i, .we_i, .adr_i,
    .dat_i, .sel_i, .dat_o, .ack_o, .fetch_valid, .fetch_byte, .fetch_ready, .dec, .op_valid, .mrm_valid,
    .flag_load, .flag_value, .flags_out);
  fetch_src i_fetch_src (.core_clk, .fetch_ready, .fetch_valid, .fetch_byte);
  // ------------------------------------------------------------
  // Clock, watchdog and helpers
  // ------------------------------------------------------------
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    close_out();
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  // One classic bus cycle, read data taken at the acknowledge edge
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do begin
      @(posedge core_clk);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic fl(logic [15:0] v);
    @(posedge core_clk);
    flag_value <= v;
    flag_load <= 1'b1;
    @(posedge core_clk);
    flag_load <= 1'b0;
    #1;
  endtask
  task automatic feed(logic [7:0] b);
    i_fetch_src.offer(b, $urandom_range(2));
  endtask
  function automatic seg_t seg_of(logic [1:0] s);
    case (s)
      2'b00: return SEG_ES;
      2'b01: return SEG_CS;
      2'b10: return SEG_SS;
      default: return SEG_DS;
    endcase
  endfunction
  function automatic seg_t mem_seg_of(logic [7:0] m, logic ov, logic [1:0] s);
    if (ov) return seg_of(s);
    if (m[2:1] == 2'b01 || (m[2:0] == 3'b110 && m[7:6] != 2'b00)) return SEG_SS;
    return SEG_DS;
  endfunction
  function automatic disp_kind_t disp_of(logic [7:0] m);
    case (m[7:6])
      2'b00: return (m[2:0] == 3'b110) ? DISP_WORD : DISP_NONE;
      2'b01: return DISP_BYTE_SEXT;
      2'b10: return DISP_WORD;
      default: return DISP_REG;
    endcase
  endfunction
  function automatic reg_id_t reg_of(logic [2:0] f, logic w);
    return w ? reg_id_t'({1'b0, f}) : reg_id_t'({1'b1, f});
  endfunction
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] op, m;
    logic [15:0] v, c0;
    logic [1:0] s;
    logic ov;
    void'($urandom(26941));
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    wb(1'b0, ADDR_FLAGS, 32'h0);
    chk("flags reset", rd, 32'h0);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h1);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = 16'($urandom);
      wb(1'b1, ADDR_FLAGS, {16'h0, v});
      wb(1'b0, ADDR_FLAGS, 32'h0);
      chk("flags sw", rd, {16'h0, v & 16'h0fd5});
      v = 16'($urandom);
      fl(v);
      chk("flags hw", {16'h0, flags_out}, {16'h0, v & 16'h0fd5});
    end
    $display("test flags done");
    for (int i = 0; i < 40; i++) begin
      op = {6'b100010, 2'($urandom)};
      m = 8'($urandom);
      ov = 1'($urandom);
      s = 2'($urandom);
      if (ov) begin
        feed({3'b001, s, 3'b110});
        chk("prefix", 32'(op_valid), 32'h0);
        i_fetch_src.take();
      end
      feed(op);
      chk("dir", 32'(dec.op.reg_is_dest), 32'(op[1]));
      chk("width", 32'(dec.op.word_op), 32'(op[0]));
      i_fetch_src.take();
      feed(m);
      chk("mode", 32'(dec.mrm.disp_kind), 32'(disp_of(m)));
      chk("reg", 32'(dec.mrm.reg_name), 32'(reg_of(m[5:3], op[0])));
      if (m[7:6] == 2'b11) chk("rm", 32'(dec.mrm.rm_name), 32'(reg_of(m[2:0], op[0])));
      else chk("seg", 32'(dec.mrm.mem_seg), 32'(mem_seg_of(m, ov, s)));
      i_fetch_src.take();
    end
    $display("test operands done");
    for (int i = 0; i < 4; i++) begin
      feed(8'h80 | 8'(i));
      chk("imm", 32'({dec.op.imm_word, dec.op.imm_sext}), 32'({i == 1, i == 3}));
      i_fetch_src.take();
      feed(8'hc0);
      i_fetch_src.take();
      feed(8'hd0 | 8'(i));
      chk("count", 32'({dec.op.count_one, dec.op.count_from_cl}), 32'({~i[1], i[1]}));
      i_fetch_src.take();
      feed(8'he0);
      i_fetch_src.take();
    end
    $display("test forms done");
    for (int i = 0; i < 8; i++) begin
      fl({9'h0, i[0], 6'h0});
      feed({7'b1111001, i[1]});
      i_fetch_src.take();
      feed({3'b001, 2'(i), 3'b110});
      i_fetch_src.take();
      feed(i[2] ? 8'hae : 8'ha7);
      chk("rep z", 32'(dec.rep_z), 32'(i[1]));
      chk("rep stop", 32'(dec.rep_stop), 32'(i[0] != i[1]));
      chk("src", 32'(dec.src_seg), 32'(seg_of(2'(i))));
      chk("dst", 32'(dec.dst_seg), 32'(SEG_ES));
      i_fetch_src.take();
    end
    feed(8'ha4);
    chk("src default", 32'(dec.src_seg), 32'(SEG_DS));
    i_fetch_src.take();
    $display("test strings done");
    wb(1'b0, ADDR_COUNT, 32'h0);
    c0 = rd[15:0];
    wb(1'b1, ADDR_CTRL, 32'h0);
    feed(8'h8b);
    repeat (3) @(posedge core_clk);
    #1;
    chk("held off", 32'({fetch_ready, op_valid}), 32'h0);
    fork
      wb(1'b1, ADDR_CTRL, 32'h1);
      i_fetch_src.take();
    join
    feed(8'hc0);
    i_fetch_src.take();
    wb(1'b0, ADDR_COUNT, 32'h0);
    chk("byte count", rd, {16'h0, c0 + 16'h2});
    wb(1'b0, ADDR_SNAP, 32'h0);
    chk("snap", rd, 32'h003f_c08b);
    $display("test enable done");
    close_out();
  end
endmodule
`default_nettype wire
